// >>> flash_seq_pkg.sv
package flash_seq_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_COMMAND     = 4'h0;
    localparam logic [3:0] ADDR_BLOCK_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_ADDR_LOW    = 4'h2;
    localparam logic [3:0] ADDR_CMP_HIGH    = 4'h3;
    localparam logic [3:0] ADDR_CMP_LOW     = 4'h4;
    localparam logic [3:0] ADDR_WRITE_BUF   = 4'h5;
    localparam logic [3:0] ADDR_STATUS      = 4'h6;
    localparam logic [3:0] ADDR_UNLOCK      = 4'h7;
    localparam logic [3:0] ADDR_MODE_CTRL   = 4'h8;
    localparam logic [3:0] ADDR_WDT_RESTART = 4'h9;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'ha;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'hb;

    // ------------------------------------------------------------
    // command codes and key values
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_VERIFY1     = 8'h01;
    localparam logic [7:0] CMD_VERIFY2     = 8'h02;
    localparam logic [7:0] CMD_BLANK_CHECK = 8'h04;
    localparam logic [7:0] CMD_BYTE_WRITE  = 8'h05;
    localparam logic [7:0] UNLOCK_KEY      = 8'ha5;
    localparam logic [7:0] WDT_KEY         = 8'hac;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int SEQ_ERR_BIT     = 0;
    localparam int VERIFY_ERR_BIT  = 1;
    localparam int PROTECT_ERR_BIT = 2;

    // interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    localparam int IRQ_WIDTH    = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 20;
    localparam int WRITE_TIME_US   = 10;
    localparam int WRITE_CYCLES    = WRITE_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_CHECK = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_DONE  = 5'b10000
    } seq_state_t;

endpackage : flash_seq_pkg

// >>> flash_array.sv
`timescale 1ns/10ps
`default_nettype none

module flash_array #(
    parameter int ADDR_W = 16
) (
    input  wire logic                        sys_clk_i,
    input  wire flash_seq_pkg::mem_req_t     req_i,
    output logic [7:0]                       rdata_o
);

    // cells start erased so that blank check and programming see known values
    logic [7:0] mem_q [0:(1<<ADDR_W)-1] = '{default: flash_seq_pkg::ERASED_BYTE};

    // ------------------------------------------------------------
    // storage; programming only clears bits, as flash cells do
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (req_i.we) begin
            mem_q[req_i.addr[ADDR_W-1:0]] <= mem_q[req_i.addr[ADDR_W-1:0]] & req_i.wdata;
        end
        rdata_o <= mem_q[req_i.addr[ADDR_W-1:0]];
    end

endmodule : flash_array

`default_nettype wire

// >>> flash_self_program_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module flash_self_program_sequencer #(
    parameter int         ADDR_W          = 16,
    parameter int         WRITE_CYCLES    = flash_seq_pkg::WRITE_CYCLES,
    parameter logic [7:0] PROTECT_BLOCKS  = 8'h00
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     resetn_i,
    input  wire flash_seq_pkg::bus_req_t  bus_i,
    output logic [7:0]                    rdata_o,
    input  wire logic                     halt_i,
    output logic                          cpu_stall_o,
    output logic                          wdt_restart_o,
    output logic                          irq_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    localparam int IRQ_WIDTH_L = flash_seq_pkg::IRQ_WIDTH;

    logic [7:0]                 command_q;
    logic [7:0]                 block_high_q;
    logic [7:0]                 addr_low_q;
    logic [7:0]                 cmp_high_q;
    logic [7:0]                 cmp_low_q;
    logic [7:0]                 write_buf_q;
    logic [7:0]                 status_q;
    logic                       prog_mode_q;
    logic [1:0]                 unlock_step_q;
    logic [7:0]                 mode_val_q;
    logic [IRQ_WIDTH_L-1:0]     irq_stat_q;
    logic [IRQ_WIDTH_L-1:0]     irq_mask_q;
    flash_seq_pkg::seq_state_t  state_q;
    logic [7:0]                 cur_q;
    logic [7:0]                 last_q;
    logic                       fail_q;
    logic [15:0]                wcount_q;
    logic [7:0]                 mem_rdata;
    flash_seq_pkg::mem_req_t    mem_req;
    logic                       done_evt;

    logic wr_cmd;
    logic wr_status;

    function automatic logic hit(input flash_seq_pkg::bus_req_t b, input logic [3:0] a);
        hit = b.wr && (b.addr == a);
    endfunction : hit

    assign wr_cmd    = hit(bus_i, flash_seq_pkg::ADDR_COMMAND);
    assign wr_status = hit(bus_i, flash_seq_pkg::ADDR_STATUS);

    // ------------------------------------------------------------
    // pointer and data registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            command_q    <= flash_seq_pkg::RESET_BYTE;
            block_high_q <= flash_seq_pkg::RESET_BYTE;
            addr_low_q   <= flash_seq_pkg::RESET_BYTE;
            cmp_high_q   <= flash_seq_pkg::RESET_BYTE;
            cmp_low_q    <= flash_seq_pkg::RESET_BYTE;
            write_buf_q  <= flash_seq_pkg::RESET_BYTE;
        end else if (state_q == flash_seq_pkg::ST_IDLE) begin
            if (wr_cmd) command_q <= bus_i.wdata;
            if (hit(bus_i, flash_seq_pkg::ADDR_BLOCK_HIGH)) block_high_q <= bus_i.wdata;
            if (hit(bus_i, flash_seq_pkg::ADDR_ADDR_LOW)) addr_low_q <= bus_i.wdata;
            if (hit(bus_i, flash_seq_pkg::ADDR_CMP_HIGH)) cmp_high_q <= bus_i.wdata;
            if (hit(bus_i, flash_seq_pkg::ADDR_CMP_LOW)) cmp_low_q <= bus_i.wdata;
            if (hit(bus_i, flash_seq_pkg::ADDR_WRITE_BUF)) write_buf_q <= bus_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // self-programming mode unlock: key, value, inverse, value
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            unlock_step_q <= 2'd0;
            mode_val_q    <= flash_seq_pkg::RESET_BYTE;
            prog_mode_q   <= 1'b0;
        end else if (hit(bus_i, flash_seq_pkg::ADDR_UNLOCK)) begin
            unlock_step_q <= (bus_i.wdata == flash_seq_pkg::UNLOCK_KEY) ? 2'd1 : 2'd0;
        end else if (hit(bus_i, flash_seq_pkg::ADDR_MODE_CTRL)) begin
            unique case (unlock_step_q)
                2'd1: begin
                    mode_val_q    <= bus_i.wdata;
                    unlock_step_q <= 2'd2;
                end
                2'd2: begin
                    unlock_step_q <= (bus_i.wdata == ~mode_val_q) ? 2'd3 : 2'd0;
                end
                2'd3: begin
                    if (bus_i.wdata == mode_val_q) prog_mode_q <= bus_i.wdata[0];
                    unlock_step_q <= 2'd0;
                end
                default: begin
                    unlock_step_q <= 2'd0;
                end
            endcase
        end else if (bus_i.wr) begin
            unlock_step_q <= 2'd0;
        end
    end

    logic seq_fail;
    assign seq_fail = hit(bus_i, flash_seq_pkg::ADDR_MODE_CTRL)
                      && ((unlock_step_q == 2'd0)
                      || (unlock_step_q == 2'd2 && bus_i.wdata != ~mode_val_q)
                      || (unlock_step_q == 2'd3 && bus_i.wdata != mode_val_q));

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    logic        cmd_known;
    logic        protected_blk;
    logic        range_bad;
    logic        set_verify;
    logic        set_protect;
    logic [7:0]  expect_byte;

    assign cmd_known = (command_q == flash_seq_pkg::CMD_BLANK_CHECK)
                    || (command_q == flash_seq_pkg::CMD_BYTE_WRITE)
                    || (command_q == flash_seq_pkg::CMD_VERIFY1)
                    || (command_q == flash_seq_pkg::CMD_VERIFY2);
    assign protected_blk = (block_high_q < PROTECT_BLOCKS);
    assign range_bad = (command_q != flash_seq_pkg::CMD_BYTE_WRITE)
                    && ((cmp_high_q != block_high_q) || (cmp_low_q < addr_low_q));
    assign expect_byte = (command_q == flash_seq_pkg::CMD_BLANK_CHECK) ? flash_seq_pkg::ERASED_BYTE
                       : (command_q == flash_seq_pkg::CMD_BYTE_WRITE) ? write_buf_q
                       : mem_rdata;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_q  <= flash_seq_pkg::ST_IDLE;
            cur_q    <= flash_seq_pkg::RESET_BYTE;
            last_q   <= flash_seq_pkg::RESET_BYTE;
            fail_q   <= 1'b0;
            wcount_q <= 16'h0000;
        end else begin
            unique case (state_q)
                flash_seq_pkg::ST_IDLE: begin
                    fail_q <= 1'b0;
                    if (halt_i && prog_mode_q && cmd_known) begin
                        cur_q  <= addr_low_q;
                        last_q <= cmp_low_q;
                        if (protected_blk || range_bad) begin
                            fail_q  <= 1'b1;
                            state_q <= flash_seq_pkg::ST_DONE;
                        end else if (command_q == flash_seq_pkg::CMD_BYTE_WRITE) begin
                            wcount_q <= 16'(WRITE_CYCLES);
                            state_q  <= flash_seq_pkg::ST_WRITE;
                        end else begin
                            state_q <= flash_seq_pkg::ST_READ;
                        end
                    end
                end
                flash_seq_pkg::ST_READ: begin
                    state_q <= flash_seq_pkg::ST_CHECK;
                end
                flash_seq_pkg::ST_CHECK: begin
                    // verify compares the cell read with itself; blank check against erased
                    if (mem_rdata != expect_byte) begin
                        fail_q  <= 1'b1;
                        state_q <= flash_seq_pkg::ST_DONE;
                    end else if (cur_q == last_q) begin
                        state_q <= flash_seq_pkg::ST_DONE;
                    end else begin
                        cur_q   <= cur_q + 8'h01;
                        state_q <= flash_seq_pkg::ST_READ;
                    end
                end
                flash_seq_pkg::ST_WRITE: begin
                    wcount_q <= wcount_q - 16'h0001;
                    if (wcount_q == 16'h0001) begin
                        // mismatch after programming means a bit could not be set
                        state_q <= flash_seq_pkg::ST_CHECK;
                        last_q  <= cur_q;
                    end
                end
                flash_seq_pkg::ST_DONE: begin
                    state_q <= flash_seq_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= flash_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign done_evt    = (state_q == flash_seq_pkg::ST_DONE);
    assign set_verify  = done_evt && fail_q && !protected_blk;
    assign set_protect = done_evt && fail_q && protected_blk;
    assign cpu_stall_o = (state_q != flash_seq_pkg::ST_IDLE);

    assign mem_req.we    = (state_q == flash_seq_pkg::ST_WRITE) && (wcount_q == 16'(WRITE_CYCLES));
    assign mem_req.addr  = {block_high_q, cur_q};
    assign mem_req.wdata = write_buf_q;

    flash_array #(
        .ADDR_W (ADDR_W)
    ) u_array (
        .sys_clk_i (sys_clk_i),
        .req_i     (mem_req),
        .rdata_o   (mem_rdata)
    );

    // ------------------------------------------------------------
    // flash status: errors stick until software writes it
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            status_q <= flash_seq_pkg::RESET_BYTE;
        end else begin
            if (wr_status) status_q <= bus_i.wdata;
            if (set_verify) status_q[flash_seq_pkg::VERIFY_ERR_BIT] <= 1'b1;
            if (set_protect) status_q[flash_seq_pkg::PROTECT_ERR_BIT] <= 1'b1;
            if (seq_fail) status_q[flash_seq_pkg::SEQ_ERR_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupts and watchdog restart
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            irq_stat_q    <= '0;
            irq_mask_q    <= '0;
            wdt_restart_o <= 1'b0;
        end else begin
            if (hit(bus_i, flash_seq_pkg::ADDR_IRQ_MASK)) irq_mask_q <= bus_i.wdata[IRQ_WIDTH_L-1:0];
            irq_stat_q <= (irq_stat_q
                          & ~(hit(bus_i, flash_seq_pkg::ADDR_IRQ_STATUS)
                              ? bus_i.wdata[IRQ_WIDTH_L-1:0] : '0))
                          | {done_evt && fail_q, done_evt};
            wdt_restart_o <= hit(bus_i, flash_seq_pkg::ADDR_WDT_RESTART)
                             && (bus_i.wdata == flash_seq_pkg::WDT_KEY);
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rdata_o <= flash_seq_pkg::RESET_BYTE;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                flash_seq_pkg::ADDR_COMMAND:    rdata_o <= command_q;
                flash_seq_pkg::ADDR_BLOCK_HIGH: rdata_o <= block_high_q;
                flash_seq_pkg::ADDR_ADDR_LOW:   rdata_o <= addr_low_q;
                flash_seq_pkg::ADDR_CMP_HIGH:   rdata_o <= cmp_high_q;
                flash_seq_pkg::ADDR_CMP_LOW:    rdata_o <= cmp_low_q;
                flash_seq_pkg::ADDR_WRITE_BUF:  rdata_o <= write_buf_q;
                flash_seq_pkg::ADDR_STATUS:     rdata_o <= status_q;
                flash_seq_pkg::ADDR_MODE_CTRL:  rdata_o <= {7'h00, prog_mode_q};
                flash_seq_pkg::ADDR_IRQ_STATUS: rdata_o <= {6'h00, irq_stat_q};
                flash_seq_pkg::ADDR_IRQ_MASK:   rdata_o <= {6'h00, irq_mask_q};
                default:                        rdata_o <= flash_seq_pkg::RESET_BYTE;
            endcase
        end else begin
            rdata_o <= flash_seq_pkg::RESET_BYTE;
        end
    end

endmodule : flash_self_program_sequencer

`default_nettype wire

// >>> flash_seq_properties.sv
`timescale 1ns/10ps
`default_nettype none

module flash_seq_checker #(
    parameter int WRITE_CYCLES = 2
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    resetn_i,
    input  wire flash_seq_pkg::bus_req_t bus_i,
    input  wire logic [7:0]              rdata_o,
    input  wire logic                    halt_i,
    input  wire logic                    cpu_stall_o,
    input  wire logic                    wdt_restart_o,
    input  wire logic                    irq_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam int STALL_MAX = 600 + WRITE_CYCLES;
    logic key_wr;
    assign key_wr = bus_i.wr && bus_i.addr == flash_seq_pkg::ADDR_WDT_RESTART
                    && bus_i.wdata == flash_seq_pkg::WDT_KEY;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // write then read of the low compare pointer while idle
    sequence s_cmp_wr_rd;
        (bus_i.wr && bus_i.addr == flash_seq_pkg::ADDR_CMP_LOW && !cpu_stall_o)
            ##1 (bus_i.rd && bus_i.addr == flash_seq_pkg::ADDR_CMP_LOW);
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_RDATA_QUIET: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_READBACK: assert property (s_cmp_wr_rd |=> rdata_o == $past(bus_i.wdata, 2))
        else $error("pointer readback differs from written value");
    AST_WDT_CAUSE: assert property (wdt_restart_o |-> $past(key_wr))
        else $error("watchdog restart without key write");
    AST_WDT_PULSE: assert property (key_wr |=> wdt_restart_o)
        else $error("key write gave no watchdog restart");
    AST_WDT_SINGLE: assert property (wdt_restart_o && !key_wr |=> !wdt_restart_o)
        else $error("watchdog restart longer than one cycle");
    AST_STALL_CAUSE: assert property ($rose(cpu_stall_o) |-> $past(halt_i))
        else $error("stall rose without halt");
    AST_IDLE_NO_STALL: assert property (!halt_i && !cpu_stall_o |=> !cpu_stall_o)
        else $error("stall started while idle without halt");
    AST_STALL_BOUNDED: assert property ($rose(cpu_stall_o) |-> ##[1:STALL_MAX] !cpu_stall_o)
        else $error("command did not finish in time");
endmodule : flash_seq_checker

bind flash_self_program_sequencer flash_seq_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .halt_i(halt_i), .cpu_stall_o(cpu_stall_o), .wdt_restart_o(wdt_restart_o), .irq_o(irq_o));

`default_nettype wire

// >>> test_flash_self_program_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module test_flash_self_program_sequencer;
    logic                    sys_clk = 1'b0;
    logic                    resetn;
    flash_seq_pkg::bus_req_t bus;
    logic [7:0]              rdata;
    logic                    halt;
    logic                    stall;
    logic                    wdt;
    logic                    irq;
    logic [7:0]              v;
    int                      err_count = 0;
    int                      n_tests = 0;
    int                      cyc = 0;
    int                      wdt_cnt = 0;

    always #25 sys_clk = ~sys_clk;

    flash_self_program_sequencer #(.WRITE_CYCLES(2), .PROTECT_BLOCKS(8'h02)) uut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .bus_i(bus), .rdata_o(rdata),
        .halt_i(halt), .cpu_stall_o(stall), .wdt_restart_o(wdt), .irq_o(irq));

    // ------------------------------------------------------------
    // run limit and watchdog pulse count
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (wdt === 1'b1) wdt_cnt++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge sys_clk);
    endtask : rd

    task automatic load(input logic [7:0] cmd, blk, lo, clo, wb);
        wr(flash_seq_pkg::ADDR_COMMAND, cmd);
        wr(flash_seq_pkg::ADDR_BLOCK_HIGH, blk);
        wr(flash_seq_pkg::ADDR_ADDR_LOW, lo);
        wr(flash_seq_pkg::ADDR_CMP_HIGH, blk);
        wr(flash_seq_pkg::ADDR_CMP_LOW, clo);
        wr(flash_seq_pkg::ADDR_WRITE_BUF, wb);
    endtask : load

    // status cleared first unless clr is low; halt then waits for the end
    task automatic launch(input logic clr, input logic exp_run);
        if (clr) wr(flash_seq_pkg::ADDR_STATUS, 8'h00);
        wr(flash_seq_pkg::ADDR_WDT_RESTART, flash_seq_pkg::WDT_KEY);
        halt <= 1'b1;
        @(posedge sys_clk);
        halt <= 1'b0;
        #1 check({7'h00, stall}, {7'h00, exp_run}, "stall after halt");
        while (stall !== 1'b0) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask : launch

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h00, "status after reset");
        rd(4'hf, v);
        check(v, 8'h00, "unmapped read");
        check({7'h00, irq}, 8'h00, "irq after reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_modes();
        int c;
        load(flash_seq_pkg::CMD_BYTE_WRITE, 8'h03, 8'h20, 8'h20, 8'h10);
        launch(1'b1, 1'b0);
        c = wdt_cnt;
        wr(flash_seq_pkg::ADDR_WDT_RESTART, 8'h12);
        check(8'(wdt_cnt - c), 8'h00, "restart on wrong key");
        wr(flash_seq_pkg::ADDR_UNLOCK, flash_seq_pkg::UNLOCK_KEY);
        wr(flash_seq_pkg::ADDR_MODE_CTRL, 8'h01);
        wr(flash_seq_pkg::ADDR_MODE_CTRL, 8'hfe);
        wr(flash_seq_pkg::ADDR_MODE_CTRL, 8'h01);
        check(8'(wdt_cnt - c), 8'h00, "restart without key");
        wr(flash_seq_pkg::ADDR_COMMAND, 8'h03);
        launch(1'b1, 1'b0);
        check(8'(wdt_cnt - c), 8'h01, "restart count");
        $display("test modes done");
    endtask : t_modes

    task automatic t_write_verify();
        load(flash_seq_pkg::CMD_BYTE_WRITE, 8'h03, 8'h20, 8'h20, 8'h10);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h00, "byte write status");
        bus <= '{addr: flash_seq_pkg::ADDR_CMP_LOW, wdata: 8'h5a, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '{addr: flash_seq_pkg::ADDR_CMP_LOW, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1 check(rdata, 8'h5a, "compare pointer readback");
        @(posedge sys_clk);
        load(flash_seq_pkg::CMD_VERIFY2, 8'h03, 8'h20, 8'h20, 8'h00);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h00, "verify range status");
        load(flash_seq_pkg::CMD_VERIFY1, 8'h03, 8'h00, 8'hff, 8'h00);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h00, "verify block status");
        load(flash_seq_pkg::CMD_BLANK_CHECK, 8'h03, 8'h00, 8'hff, 8'h00);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h02, "blank check of written block");
        load(flash_seq_pkg::CMD_BYTE_WRITE, 8'h03, 8'h20, 8'h20, 8'h01);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h02, "write over programmed byte");
        $display("test write and verify done");
    endtask : t_write_verify

    task automatic t_protect();
        load(flash_seq_pkg::CMD_BYTE_WRITE, 8'h01, 8'h20, 8'h20, 8'h10);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h04, "protected write status");
        load(flash_seq_pkg::CMD_VERIFY2, 8'h03, 8'h20, 8'h20, 8'h00);
        launch(1'b0, 1'b1);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h04, "flag kept over next command");
        wr(flash_seq_pkg::ADDR_STATUS, 8'h00);
        rd(flash_seq_pkg::ADDR_STATUS, v);
        check(v, 8'h00, "status cleared by write");
        $display("test protect done");
    endtask : t_protect

    task automatic t_irq();
        wr(flash_seq_pkg::ADDR_IRQ_STATUS, 8'h03);
        rd(flash_seq_pkg::ADDR_IRQ_STATUS, v);
        check(v, 8'h00, "irq status cleared");
        wr(flash_seq_pkg::ADDR_IRQ_MASK, 8'h00);
        launch(1'b1, 1'b1);
        rd(flash_seq_pkg::ADDR_IRQ_STATUS, v);
        check(v, 8'h01, "done event recorded");
        check({7'h00, irq}, 8'h00, "irq while masked");
        wr(flash_seq_pkg::ADDR_IRQ_MASK, 8'h03);
        check({7'h00, irq}, 8'h01, "irq when unmasked");
        wr(flash_seq_pkg::ADDR_IRQ_STATUS, 8'h01);
        check({7'h00, irq}, 8'h00, "irq after clear");
        $display("test irq done");
    endtask : t_irq

    initial begin
        bus = '0;
        halt = 1'b0;
        resetn = 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_modes();
        t_write_verify();
        t_protect();
        t_irq();
        conclude();
    end
endmodule : test_flash_self_program_sequencer

`default_nettype wire
